/* File: rtl/isi_gate.v */
// isi_gate.v: or of flags each anded with its enable, registered
// assumes flags and enables on the same clock
`timescale 1ns/1ns
module isi_gate #(
	parameter N = 1
) (
	input  wire         ref_clk_i,
	input  wire         reset_n_i,
	input  wire [N-1:0] flag_i,
	input  wire [N-1:0] en_i,
	output reg          hit_o
);
	always @(posedge ref_clk_i) begin
		if (!reset_n_i) begin
			hit_o <= 1'b0;
		end else begin
			hit_o <= |(flag_i & en_i);
		end
	end
endmodule

/* File: rtl/isi_regs.vh */
// isi_regs.vh: constants for the interrupt identification block
// assumes inclusion by bare name from the rtl folder
// Overview of operation
// - flags set regardless of any enable
// - every accepted interrupt goes to vector address
// - one pending bit per peripheral module
// - one extra pending bit for system sources
// - vector address writable anywhere in program memory
// - vector address resets to zero
// - source registers only for modules one, two
// - nine i2c target pairs merge into bit
// - converter events merge; three-wire separate bit
// - spi: three flags shared enable, fault separate
// - mode fault gated by its own enable
// - external channel zero has own flag, enable
// - source bit is and of flag and enable
// - source registers 16 bits, read-only, reset zero
`ifndef ISI_REGS_VH
`define ISI_REGS_VH
`define ISI_VEC_W       16
`define ISI_VEC_RST     16'h0000
`define ISI_SRC_W       16
`define ISI_SRC_RST     16'h0000
`define ISI_PEND_W      7
`define ISI_PEND_RST    7'h00
`define ISI_MASK_RST    7'h00
`define ISI_I2C_N       9
`define ISI_ADC_N       6
`define ISI_THR_N       16
`define ISI_EXT1_N      8
`define ISI_M1_EXT_N    7
// module one source bits
`define ISI_M1_SVM      7
`define ISI_M1_I2CC     8
`define ISI_M1_SPIT     10
// module two source bits
`define ISI_M2_TW       0
`define ISI_M2_ADC      1
`define ISI_M2_I2CT     2
// module pending bit positions (system bit last)
`define ISI_PB_M0       0
`define ISI_PB_M1       1
`define ISI_PB_M2       2
`define ISI_PB_M3       3
`define ISI_PB_M4       4
`define ISI_PB_M5       5
`define ISI_PB_SYS      6
`endif

/* File: rtl/isi_top.v */
// isi_top.v: interrupt identification, masking and vectoring
// assumes peripheral flags and enables come from core-clock logic;
// flags are held by the peripherals and cleared by software there
`timescale 1ns/1ns
`include "isi_regs.vh"
module isi_top (
	input  wire                   ref_clk_i,
	input  wire                   reset_n_i,
	// module 0 (external pins, timer 1), gated here by its enables
	input  wire [`ISI_EXT1_N-1:0] m0_flag_i,
	input  wire [`ISI_EXT1_N-1:0] m0_en_i,
	// module 1 sources
	input  wire [`ISI_M1_EXT_N-1:0] m1_ext_flag_i,
	input  wire [`ISI_M1_EXT_N-1:0] m1_ext_en_i,
	input  wire                   m1_svm_flag_i,
	input  wire                   m1_svm_en_i,
	input  wire [`ISI_I2C_N-1:0]  m1_i2cc_flag_i,
	input  wire [`ISI_I2C_N-1:0]  m1_i2cc_en_i,
	input  wire [2:0]             m1_spit_flag_i,
	input  wire                   m1_spit_en_i,
	// module 2: i2c target status and enables
	input  wire [`ISI_I2C_N-1:0]  i2c_target_status_i,
	input  wire [`ISI_I2C_N-1:0]  i2c_target_irq_enable_i,
	// converter: done, int temp, ext0, ext1, sh0, sh1
	input  wire [`ISI_ADC_N-1:0]  converter_status_i,
	input  wire [`ISI_ADC_N-1:0]  converter_enables_i,
	input  wire                   three_wire_flag_i,
	input  wire                   three_wire_enable_i,
	// module 3: timer 2
	input  wire                   timer2_flag_i,
	input  wire                   timer2_enable_i,
	// modules 4 and 5: thresholds
	input  wire [`ISI_THR_N-1:0]  low_threshold_flags_i,
	input  wire [`ISI_THR_N-1:0]  low_threshold_enables_i,
	input  wire [`ISI_THR_N-1:0]  high_threshold_flags_i,
	input  wire [`ISI_THR_N-1:0]  high_threshold_enables_i,
	// spi controller: complete, collision, overrun, mode fault
	input  wire [3:0]             spi_controller_flags_i,
	input  wire                   spi_irq_enable_i,
	input  wire                   mode_fault_enable_i,
	// system: watchdog
	input  wire                   watchdog_flag_i,
	input  wire                   watchdog_enable_i,
	// masking and vector
	input  wire [`ISI_PEND_W-1:0] module_mask_i,
	input  wire                   global_enable_i,
	input  wire                   vector_write_i,
	input  wire [`ISI_VEC_W-1:0]  vector_wdata_i,
	input  wire                   irq_accept_i,
	output reg  [`ISI_VEC_W-1:0]  vector_address_reg_o,
	output reg  [`ISI_PEND_W-1:0] module_pending_reg_o,
	output reg  [`ISI_SRC_W-1:0]  module_one_source_reg_o,
	output reg  [`ISI_SRC_W-1:0]  module_two_source_reg_o,
	output reg                    irq_request_o,
	output reg                    jump_o,
	output reg  [`ISI_VEC_W-1:0]  jump_target_o
);
	//--------------------------------------------------
	// per-function gating
	//--------------------------------------------------
	wire       g_svm;
	wire       g_i2cc;
	wire       g_spit;
	wire       g_i2ct;
	wire       g_adc;
	wire       g_tw;
	wire       g_m0;
	wire       g_t2;
	wire       g_lt;
	wire       g_ht;
	wire       g_spic;
	wire       g_wd;
	wire [`ISI_M1_EXT_N-1:0] g_ext;
	genvar i;
	generate
		for (i = 0; i < `ISI_M1_EXT_N; i = i + 1) begin : g_pin
			isi_gate #(.N(1)) u_pin (
				.ref_clk_i (ref_clk_i),
				.reset_n_i (reset_n_i),
				.flag_i    (m1_ext_flag_i[i]),
				.en_i      (m1_ext_en_i[i]),
				.hit_o     (g_ext[i])
			);
		end
	endgenerate
	isi_gate #(.N(1)) u_svm (
		.ref_clk_i (ref_clk_i),
		.reset_n_i (reset_n_i),
		.flag_i    (m1_svm_flag_i),
		.en_i      (m1_svm_en_i),
		.hit_o     (g_svm)
	);
	isi_gate #(.N(`ISI_I2C_N)) u_i2cc (
		.ref_clk_i (ref_clk_i),
		.reset_n_i (reset_n_i),
		.flag_i    (m1_i2cc_flag_i),
		.en_i      (m1_i2cc_en_i),
		.hit_o     (g_i2cc)
	);
	isi_gate #(.N(3)) u_spit (
		.ref_clk_i (ref_clk_i),
		.reset_n_i (reset_n_i),
		.flag_i    (m1_spit_flag_i),
		.en_i      ({3{m1_spit_en_i}}),
		.hit_o     (g_spit)
	);
	// nine target flag/enable pairs, one bit
	isi_gate #(.N(`ISI_I2C_N)) u_i2ct (
		.ref_clk_i (ref_clk_i),
		.reset_n_i (reset_n_i),
		.flag_i    (i2c_target_status_i),
		.en_i      (i2c_target_irq_enable_i),
		.hit_o     (g_i2ct)
	);
	// bit 2 is external channel zero with its own enable
	isi_gate #(.N(`ISI_ADC_N)) u_adc (
		.ref_clk_i (ref_clk_i),
		.reset_n_i (reset_n_i),
		.flag_i    (converter_status_i),
		.en_i      (converter_enables_i),
		.hit_o     (g_adc)
	);
	isi_gate #(.N(1)) u_tw (
		.ref_clk_i (ref_clk_i),
		.reset_n_i (reset_n_i),
		.flag_i    (three_wire_flag_i),
		.en_i      (three_wire_enable_i),
		.hit_o     (g_tw)
	);
	isi_gate #(.N(`ISI_EXT1_N)) u_m0 (
		.ref_clk_i (ref_clk_i),
		.reset_n_i (reset_n_i),
		.flag_i    (m0_flag_i),
		.en_i      (m0_en_i),
		.hit_o     (g_m0)
	);
	isi_gate #(.N(1)) u_t2 (
		.ref_clk_i (ref_clk_i),
		.reset_n_i (reset_n_i),
		.flag_i    (timer2_flag_i),
		.en_i      (timer2_enable_i),
		.hit_o     (g_t2)
	);
	isi_gate #(.N(`ISI_THR_N)) u_lt (
		.ref_clk_i (ref_clk_i),
		.reset_n_i (reset_n_i),
		.flag_i    (low_threshold_flags_i),
		.en_i      (low_threshold_enables_i),
		.hit_o     (g_lt)
	);
	isi_gate #(.N(`ISI_THR_N)) u_ht (
		.ref_clk_i (ref_clk_i),
		.reset_n_i (reset_n_i),
		.flag_i    (high_threshold_flags_i),
		.en_i      (high_threshold_enables_i),
		.hit_o     (g_ht)
	);
	// three flags share one enable, mode fault its own
	isi_gate #(.N(4)) u_spic (
		.ref_clk_i (ref_clk_i),
		.reset_n_i (reset_n_i),
		.flag_i    (spi_controller_flags_i),
		.en_i      ({mode_fault_enable_i, {3{spi_irq_enable_i}}}),
		.hit_o     (g_spic)
	);
	isi_gate #(.N(1)) u_wd (
		.ref_clk_i (ref_clk_i),
		.reset_n_i (reset_n_i),
		.flag_i    (watchdog_flag_i),
		.en_i      (watchdog_enable_i),
		.hit_o     (g_wd)
	);

	//--------------------------------------------------
	// source and pending registers
	//--------------------------------------------------
	reg [`ISI_SRC_W-1:0]  src1_d;
	reg [`ISI_SRC_W-1:0]  src2_d;
	reg [`ISI_PEND_W-1:0] pend_d;
	always @* begin
		src1_d = `ISI_SRC_RST;
		src1_d[`ISI_M1_EXT_N-1:0] = g_ext;
		src1_d[`ISI_M1_SVM] = g_svm;
		src1_d[`ISI_M1_I2CC] = g_i2cc;
		src1_d[`ISI_M1_SPIT] = g_spit;
		src2_d = `ISI_SRC_RST;
		src2_d[`ISI_M2_TW] = g_tw;
		src2_d[`ISI_M2_ADC] = g_adc;
		src2_d[`ISI_M2_I2CT] = g_i2ct;
		pend_d = `ISI_PEND_RST;
		pend_d[`ISI_PB_M0] = g_m0;
		pend_d[`ISI_PB_M1] = |src1_d;
		pend_d[`ISI_PB_M2] = |src2_d;
		pend_d[`ISI_PB_M3] = g_t2;
		pend_d[`ISI_PB_M4] = g_lt | g_spic;
		pend_d[`ISI_PB_M5] = g_ht;
		pend_d[`ISI_PB_SYS] = g_wd;
	end

	always @(posedge ref_clk_i) begin
		if (!reset_n_i) begin
			module_one_source_reg_o <= `ISI_SRC_RST;
			module_two_source_reg_o <= `ISI_SRC_RST;
			module_pending_reg_o    <= `ISI_PEND_RST;
			irq_request_o           <= 1'b0;
		end else begin
			module_one_source_reg_o <= src1_d;
			module_two_source_reg_o <= src2_d;
			// pending shows sources whatever the mask and global enable
			module_pending_reg_o    <= pend_d;
			irq_request_o <= global_enable_i &
				|(pend_d & module_mask_i);
		end
	end

	//--------------------------------------------------
	// vector address and jump
	//--------------------------------------------------
	always @(posedge ref_clk_i) begin
		if (!reset_n_i) begin
			vector_address_reg_o <= `ISI_VEC_RST;
			jump_o               <= 1'b0;
			jump_target_o        <= `ISI_VEC_RST;
		end else begin
			if (vector_write_i) begin
				vector_address_reg_o <= vector_wdata_i;
			end
			jump_o <= irq_accept_i & irq_request_o;
			if (irq_accept_i & irq_request_o) begin
				jump_target_o <= vector_address_reg_o;
			end
		end
	end
endmodule

/* File: verification/isi_checker.sv */
// isi_checker.sv: port assertions for isi_top, bound below
// assumes one core clock and a sync active-low reset
`timescale 1ns/1ns
module isi_checker (
	input wire logic        ref_clk_i,
	input wire logic        reset_n_i,
	input wire logic [15:0] high_threshold_flags_i,
	input wire logic [15:0] high_threshold_enables_i,
	input wire logic        watchdog_flag_i,
	input wire logic        watchdog_enable_i,
	input wire logic [6:0]  module_mask_i,
	input wire logic        global_enable_i,
	input wire logic        vector_write_i,
	input wire logic [15:0] vector_wdata_i,
	input wire logic        irq_accept_i,
	input wire logic [15:0] vector_address_reg_o,
	input wire logic [6:0]  module_pending_reg_o,
	input wire logic        irq_request_o,
	input wire logic        jump_o,
	input wire logic [15:0] jump_target_o
);
	// up_q[1]: two clean edges since reset, so a depth-2 past is valid
	logic [1:0] up_q;
	always @(posedge ref_clk_i)
		up_q <= reset_n_i ? {up_q[0], 1'b1} : 2'b00;
	default clocking cb @(posedge ref_clk_i); endclocking
	default disable iff (!reset_n_i);
	sequence s_take; irq_accept_i && irq_request_o && !vector_write_i; endsequence
	sequence s_gone; !(irq_accept_i && irq_request_o); endsequence
	property p_vec_rst; disable iff (1'b0)
		!reset_n_i |=> vector_address_reg_o == 16'h0000; endproperty
	a_vec_rst: assert property (p_vec_rst) else $error("vec rst");
	property p_vec_wr;
		vector_write_i |=> vector_address_reg_o == $past(vector_wdata_i);
	endproperty
	a_vec_wr: assert property (p_vec_wr) else $error("vec wr");
	property p_vec_hold; !vector_write_i |=> $stable(vector_address_reg_o);
	endproperty
	a_vec_hold: assert property (p_vec_hold) else $error("vec hold");
	property p_jump;
		s_take |=> jump_o && jump_target_o == $past(vector_address_reg_o);
	endproperty
	a_jump: assert property (p_jump) else $error("jump");
	property p_no_jump; s_gone |=> !jump_o; endproperty
	a_no_jump: assert property (p_no_jump) else $error("no jump");
	property p_sys; up_q[1] |-> module_pending_reg_o[6] ==
		$past(watchdog_flag_i & watchdog_enable_i, 2); endproperty
	a_sys: assert property (p_sys) else $error("sys bit");
	property p_high; up_q[1] |-> module_pending_reg_o[5] ==
		$past(|(high_threshold_flags_i & high_threshold_enables_i), 2);
	endproperty
	a_high: assert property (p_high) else $error("high bit");
	property p_irq; irq_request_o == (|(module_pending_reg_o &
		$past(module_mask_i)) && $past(global_enable_i)); endproperty
	a_irq: assert property (p_irq) else $error("irq");
endmodule

bind isi_top isi_checker u_chk (.*);

/* File: verification/tb_top.sv */
// tb_top.sv: self-checking random bench for isi_top
// assumes rtl/isi_top.v, its header and the checker are compiled
`timescale 1ns/1ns
module tb_top;
	logic ref_clk_i, reset_n_i, m1_svm_flag_i, m1_svm_en_i, m1_spit_en_i;
	logic three_wire_flag_i, three_wire_enable_i, timer2_flag_i, jump_o;
	logic timer2_enable_i, spi_irq_enable_i, mode_fault_enable_i;
	logic watchdog_flag_i, watchdog_enable_i, global_enable_i;
	logic vector_write_i, irq_accept_i, irq_request_o;
	logic [2:0] m1_spit_flag_i;
	logic [3:0] spi_controller_flags_i;
	logic [5:0] converter_status_i, converter_enables_i;
	logic [6:0] m1_ext_flag_i, m1_ext_en_i, module_mask_i;
	logic [6:0] module_pending_reg_o;
	logic [7:0] m0_flag_i, m0_en_i;
	logic [8:0] m1_i2cc_flag_i, m1_i2cc_en_i;
	logic [8:0] i2c_target_status_i, i2c_target_irq_enable_i;
	logic [15:0] low_threshold_flags_i, low_threshold_enables_i;
	logic [15:0] high_threshold_flags_i, high_threshold_enables_i;
	logic [15:0] vector_wdata_i, vector_address_reg_o, jump_target_o;
	logic [15:0] module_one_source_reg_o, module_two_source_reg_o, v;
	integer seed, i;
	int err_count, tests_run, cycles = 0;
	isi_top u_dut (.*);
	initial begin
		ref_clk_i = 0;
		forever #2 ref_clk_i = ~ref_clk_i;
	end
	function automatic logic [127:0] rnd();
		rnd = {$random(seed), $random(seed), $random(seed), $random(seed)};
	endfunction
	task automatic set_in(input logic [127:0] f, e);
		{m0_flag_i, m1_ext_flag_i, m1_svm_flag_i, m1_i2cc_flag_i,
		 m1_spit_flag_i, i2c_target_status_i, converter_status_i,
		 three_wire_flag_i, timer2_flag_i, low_threshold_flags_i,
		 high_threshold_flags_i, spi_controller_flags_i,
		 watchdog_flag_i} = f[81:0];
		{m0_en_i, m1_ext_en_i, m1_svm_en_i, m1_i2cc_en_i, m1_spit_en_i,
		 i2c_target_irq_enable_i, converter_enables_i, three_wire_enable_i,
		 timer2_enable_i, low_threshold_enables_i, high_threshold_enables_i,
		 spi_irq_enable_i, mode_fault_enable_i, watchdog_enable_i,
		 module_mask_i, global_enable_i} = e[85:0];
	endtask
	function automatic logic [15:0] exp_src1();
		exp_src1 = {5'h00, |m1_spit_flag_i & m1_spit_en_i, 1'b0,
			|(m1_i2cc_flag_i & m1_i2cc_en_i), m1_svm_flag_i & m1_svm_en_i,
			m1_ext_flag_i & m1_ext_en_i};
	endfunction
	function automatic logic [15:0] exp_src2();
		exp_src2 = {13'h0000, |(i2c_target_status_i & i2c_target_irq_enable_i),
			|(converter_status_i & converter_enables_i),
			three_wire_flag_i & three_wire_enable_i};
	endfunction
	function automatic logic [6:0] exp_pend();
		exp_pend = {watchdog_flag_i & watchdog_enable_i,
			|(high_threshold_flags_i & high_threshold_enables_i),
			|(low_threshold_flags_i & low_threshold_enables_i) |
			(|spi_controller_flags_i[2:0] & spi_irq_enable_i) |
			(spi_controller_flags_i[3] & mode_fault_enable_i),
			timer2_flag_i & timer2_enable_i, |exp_src2(), |exp_src1(),
			|(m0_flag_i & m0_en_i)};
	endfunction
	task automatic check(input string n, input logic [15:0] seen, exp);
		tests_run++;
		if (seen !== exp) begin
			err_count++;
			$display("CHECK FAILED %s expected %h seen %h", n, exp, seen);
		end
	endtask
	task automatic test_done();
		$display("checks %0d mismatches %0d", tests_run, err_count);
		if (err_count == 0 && tests_run > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	task automatic tick(input int n);
		repeat (n) @(posedge ref_clk_i);
		#1;
	endtask
	always @(posedge ref_clk_i) begin
		cycles++;
		if (cycles == 3000) begin
			err_count++;
			test_done();
		end
	end
	initial begin
		seed = 78;
		{reset_n_i, vector_write_i, vector_wdata_i, irq_accept_i} = 0;
		set_in(128'h0, 128'h0);
		tick(12);
		reset_n_i = 1;
		tick(1);
		check("vector", vector_address_reg_o, 16'h0000);
		// all flags up but nothing enabled, then random mixes
		for (i = 0; i < 300; i++) begin
			if (i == 0)
				set_in({128{1'b1}}, 128'h0);
			else
				set_in(rnd() & rnd() & rnd(), rnd());
			tick(3);
			check("pending", module_pending_reg_o, exp_pend());
			check("src1", module_one_source_reg_o, exp_src1());
			check("src2", module_two_source_reg_o, exp_src2());
			check("irq", irq_request_o, |(exp_pend() & module_mask_i) &
				global_enable_i);
		end
		for (i = 0; i < 2; i++) begin
			v = i ? 16'(rnd()) : 16'hFFFF;
			vector_write_i = 1;
			vector_wdata_i = v;
			tick(1);
			vector_write_i = 0;
			check("vector", vector_address_reg_o, v);
			set_in(128'h1, 128'h1FF);
			tick(3);
			check("irq", irq_request_o, 1'b1);
			irq_accept_i = 1;
			tick(1);
			irq_accept_i = 0;
			check("jump", jump_o, 1'b1);
			check("target", jump_target_o, v);
			tick(1);
			check("jump", jump_o, 1'b0);
			// handler clears the flag, request must drop
			set_in(128'h0, 128'h1FF);
			tick(3);
			check("irq", irq_request_o, 1'b0);
		end
		// every source up and enabled, mask and global off
		set_in({128{1'b1}}, {{120{1'b1}}, 8'h00});
		tick(3);
		check("pending", module_pending_reg_o, exp_pend());
		check("irq", irq_request_o, 1'b0);
		reset_n_i = 0;
		tick(1);
		check("src1", module_one_source_reg_o, 16'h0000);
		check("src2", module_two_source_reg_o, 16'h0000);
		check("pending", module_pending_reg_o, 16'h0000);
		reset_n_i = 1;
		tick(1);
		check("vector", vector_address_reg_o, 16'h0000);
		test_done();
	end
endmodule
